/* common/fbcfg_pkg.sv */
// package for the fieldbus and boot configuration register bank
// assumes a 125 MHz single clock and 32-bit avalon data
package fbcfg_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_ENC_BOOT_POS  = 16'h205A;
    localparam logic [15:0] IDX_STEP_MODE     = 16'h205B;
    localparam logic [15:0] IDX_BOOT_DELAY    = 16'h2084;
    localparam logic [15:0] IDX_PRESENCE      = 16'h2101;
    localparam logic [15:0] IDX_ENABLE_CTRL   = 16'h2102;
    localparam logic [15:0] IDX_SWITCH_MASK   = 16'h2103;
    localparam logic [15:0] IDX_ACTIVE_STAT   = 16'h2104;
    localparam logic [15:0] IDX_READY_STAT    = 16'h2105;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [31:0] RST_ZERO          = 32'h0000_0000;
    localparam logic [31:0] RST_LINK_MAP      = 32'h001B_0011;
    localparam int          PHYS_LO           = 0;
    localparam int          PHYS_HI           = 15;
    localparam int          PROTO_LO          = 16;
    localparam int          PROTO_HI          = 31;
    localparam int          USB_BIT           = 0;
    localparam int          DIFFERENTIAL_SERIAL_BIT = 1;
    localparam int          SINGLE_ENDED_SERIAL_BIT = 2;
    localparam int          CANOPEN_BIT       = 3;
    localparam int          ETHERNET_PHYS_BIT = 4;
    localparam int          INDUSTRIAL_ETHERNET_BIT = 5;
    localparam int          SPI_BIT           = 6;
    localparam int          SERIAL_REGISTER_PROTOCOL_BIT = 16;
    localparam int          TCP_REGISTER_PROTOCOL_BIT    = 17;
    localparam int          INDUSTRIAL_IP_PROTOCOL_BIT   = 18;
    localparam logic        MODE_CLOCK_DIR    = 1'b0;
    localparam logic        MODE_ROTATION     = 1'b1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_FREQ_KHZ      = 125000;
    localparam int          MS_TIME           = 1;
    localparam int          CYCLES_PER_MS     = MS_TIME * CLK_FREQ_KHZ;

    typedef enum logic [1:0] {BOOT_CAPTURE, BOOT_WAIT, BOOT_READY} boot_t;
endpackage

/* logic/fbcfg_regs.sv */
// fieldbus and boot configuration register bank, avalon-mm slave
// assumes a synchronous master honouring waitrequest, one clock
//
// Notes on behaviour
// - boot position reads zero without absolute encoder
// - boot position captured once, signed, read only
// - mode 0 clock-direction, 1 rotation
// - wait boot delay ms before ready
// - low half interfaces, high half protocols
// - fixed bit positions per link
// - presence map read only, reset 001B0011
// - control word switches links, same positions
// - only masked links switch, active reported
// - control word resets to 001B0011
// - mask bit one means may deactivate
// - active bit one means link active
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module fbcfg_regs #(
    parameter logic [31:0] SWITCHABLE = 32'h0000_0000, // switch mask
    parameter int          MS_CYCLES  = fbcfg_pkg::CYCLES_PER_MS // ms
) (
    input  wire logic        clk,             // system clock
    input  wire logic        rst_b,           // async reset, active low
    input  wire logic [15:0] address,         // word index
    input  wire logic        read,            // read request
    input  wire logic        write,           // write request
    input  wire logic [31:0] writedata,       // write data
    input  wire logic [3:0]  byteenable,      // byte lanes
    output logic [31:0]      readdata,        // read data
    output logic             waitrequest,     // stall
    output logic [1:0]       response,        // 00 ok, 10 slave error
    input  wire logic        absEncoderFitted,// absolute encoder present
    input  wire logic signed [31:0] encoderPosUser, // position, user units
    output logic             stepRotationMode,// 1 rotation, 0 clock-dir
    output logic             deviceReady,     // boot delay elapsed
    output logic [31:0]      linkActive       // active fieldbus set
);
    import fbcfg_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic isMapped(input logic [15:0] a);
        case (a)
            IDX_ENC_BOOT_POS, IDX_STEP_MODE, IDX_BOOT_DELAY,
            IDX_PRESENCE, IDX_ENABLE_CTRL, IDX_SWITCH_MASK,
            IDX_ACTIVE_STAT, IDX_READY_STAT: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            laneMerge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic signed [31:0] encBootPos;
    logic [31:0]        stepMode;
    logic [31:0]        bootDelay;
    logic [31:0]        enableCtrl;
    logic [31:0]        presence;
    logic [31:0]        msCount;
    logic               msTick;
    logic               answered;
    logic               wrHit;
    boot_t              bootState;

    assign presence = RST_LINK_MAP;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait state: every request is answered on the second edge;
    // a write lands only at the edge where the master sees the answer
    assign waitrequest = (read | write) & ~answered;
    assign wrHit       = write & answered;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            answered <= 1'b0;
        end else begin
            answered <= (read | write) & ~answered;
        end
    end

    // read data and response registered on the first edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= RST_ZERO;
            response <= 2'h0;
        end else if ((read | write) & ~answered) begin
            response <= isMapped(address) ? 2'h0 : 2'h2;
            readdata <= RST_ZERO;
            if (read) begin
                case (address)
                    IDX_ENC_BOOT_POS: readdata <= encBootPos;
                    IDX_STEP_MODE:    readdata <= stepMode;
                    IDX_BOOT_DELAY:   readdata <= bootDelay;
                    IDX_PRESENCE:     readdata <= presence;
                    IDX_ENABLE_CTRL:  readdata <= enableCtrl;
                    IDX_SWITCH_MASK:  readdata <= SWITCHABLE;
                    IDX_ACTIVE_STAT:  readdata <= linkActive;
                    IDX_READY_STAT:   readdata <= {31'h0, deviceReady};
                    default:          readdata <= RST_ZERO;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    // step mode selector
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stepMode <= RST_ZERO;
        end else if (wrHit && address == IDX_STEP_MODE) begin
            stepMode <= laneMerge(stepMode, writedata, byteenable);
        end
    end
    assign stepRotationMode = (stepMode[0] == MODE_ROTATION);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bootDelay <= RST_ZERO;
        end else if (wrHit && address == IDX_BOOT_DELAY) begin
            bootDelay <= laneMerge(bootDelay, writedata, byteenable);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enableCtrl <= RST_LINK_MAP;
        end else if (wrHit && address == IDX_ENABLE_CTRL) begin
            enableCtrl <= laneMerge(enableCtrl, writedata, byteenable);
        end
    end

    // ------------------------------------------------------------
    // boot sequence
    // ------------------------------------------------------------
    ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (msTick)
    );

    // capture position after release, then count delay in ms
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bootState  <= BOOT_CAPTURE;
            encBootPos <= RST_ZERO;
            msCount    <= RST_ZERO;
        end else begin
            case (bootState)
                BOOT_CAPTURE: begin
                    encBootPos <= absEncoderFitted ? encoderPosUser
                                                   : RST_ZERO;
                    bootState  <= BOOT_WAIT;
                end
                BOOT_WAIT: begin
                    if (msCount >= bootDelay) begin
                        bootState <= BOOT_READY;
                    end else if (msTick) begin
                        msCount <= msCount + 32'h0000_0001;
                    end
                end
                BOOT_READY: bootState <= BOOT_READY;
                default:    bootState <= BOOT_CAPTURE;
            endcase
        end
    end
    assign deviceReady = (bootState == BOOT_READY);

    // ------------------------------------------------------------
    // active fieldbus set
    // ------------------------------------------------------------
    // mask one means switchable
    link_switch #(.WIDTH(32)) u_switch (
        .clk        (clk),
        .rst_b      (rst_b),
        .enableCtrl (enableCtrl),
        .switchMask (SWITCHABLE),
        .presence   (presence),
        .activeSet  (linkActive)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // fixed link layout
    chk_presence_fixed: assert property (@(posedge clk) disable iff (!rst_b)
        presence[USB_BIT] && presence[ETHERNET_PHYS_BIT]
        && presence[SERIAL_REGISTER_PROTOCOL_BIT]
        && presence[TCP_REGISTER_PROTOCOL_BIT]
        && !presence[INDUSTRIAL_IP_PROTOCOL_BIT]
        && presence[PROTO_HI:PROTO_LO] == RST_LINK_MAP[PROTO_HI:PROTO_LO]
        && presence[PHYS_HI:PHYS_LO] == RST_LINK_MAP[PHYS_HI:PHYS_LO])
        else $error("presence map changed");

    chk_boot_frozen: assert property (@(posedge clk) disable iff (!rst_b)
        bootState != BOOT_CAPTURE |=> $stable(encBootPos))
        else $error("boot position changed after capture");

    chk_no_encoder_zero: assert property (@(posedge clk) disable iff (!rst_b)
        bootState == BOOT_CAPTURE && !absEncoderFitted
        |=> encBootPos == RST_ZERO)
        else $error("boot position not zero without encoder");

    chk_mode_follows: assert property (@(posedge clk) disable iff (!rst_b)
        wrHit && address == IDX_STEP_MODE && byteenable[0]
        |=> stepRotationMode == $past(writedata[0]))
        else $error("step mode not updated");

    chk_ready_delay: assert property (@(posedge clk) disable iff (!rst_b)
        deviceReady |-> msCount >= bootDelay || $past(deviceReady))
        else $error("ready before delay");

    chk_presence_ro: assert property (@(posedge clk) disable iff (!rst_b)
        read && !answered && address == IDX_PRESENCE
        |=> readdata == RST_LINK_MAP)
        else $error("presence read wrong");

    chk_ctrl_write: assert property (@(posedge clk) disable iff (!rst_b)
        wrHit && address == IDX_ENABLE_CTRL && byteenable == 4'hF
        |=> enableCtrl == $past(writedata))
        else $error("control write lost");

    chk_fixed_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (linkActive & ~SWITCHABLE) == (RST_LINK_MAP & ~SWITCHABLE))
        else $error("unswitchable link changed");

    chk_wait_one: assert property (@(posedge clk) disable iff (!rst_b)
        (read || write) && !answered |-> waitrequest ##1 !waitrequest)
        else $error("answer not after one wait state");
endmodule

/* logic/link_switch.sv */
// fieldbus active-set logic for one bit per link
// assumes the control word and mask come from the register bank
`timescale 1ns/1ns
module link_switch #(
    parameter int WIDTH = 32  // number of link bits
) (
    input  wire logic             clk,         // system clock
    input  wire logic             rst_b,       // async reset, active low
    input  wire logic [WIDTH-1:0] enableCtrl,  // software enable word
    input  wire logic [WIDTH-1:0] switchMask,  // bits that may switch
    input  wire logic [WIDTH-1:0] presence,    // bits fitted
    output logic      [WIDTH-1:0] activeSet    // links now active
);
    import fbcfg_pkg::*;

    // per-bit state: a bit follows control only when switchable
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_bit
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    activeSet[g] <= RST_LINK_MAP[g];
                end else if (switchMask[g]) begin
                    activeSet[g] <= enableCtrl[g] & presence[g];
                end
            end
        end
    endgenerate
endmodule

/* logic/ms_tick.sv */
// millisecond enable divider
// assumes one free-running clock; tick is a one-cycle pulse
`timescale 1ns/1ns
module ms_tick #(
    parameter int CYCLES = fbcfg_pkg::CYCLES_PER_MS  // cycles per tick
) (
    input  wire logic clk,    // system clock
    input  wire logic rst_b,  // async reset, active low
    output logic      tick    // one pulse per period
);
    import fbcfg_pkg::*;

    logic [31:0] count;

    // free-running divider, restarts after each tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule

/* sim/fbcfg_regs_bench.sv */
// self-checking bench for the fieldbus and boot configuration bank
// assumes the slave answers through waitrequest and a 4-cycle millisecond
`timescale 1ns/1ns
module fbcfg_regs_bench;
    import fbcfg_pkg::*;

    // ------------------------------------------------------------
    // stimulus signals and scoreboard
    // ------------------------------------------------------------
    localparam logic [31:0] MASK = 32'h0003_0010; // links 4, 16, 17
    typedef struct {logic [31:0] d; logic [1:0] r; bit useD;} note_t;
    logic               clk              = 1'b0;
    logic               rst_b            = 1'b0;
    logic        [15:0] address          = 16'h0000;
    logic               read             = 1'b0;
    logic               write            = 1'b0;
    logic        [31:0] writedata        = 32'h0000_0000;
    logic        [3:0]  byteenable       = 4'hF;
    logic        [31:0] readdata;
    logic               waitrequest;
    logic        [1:0]  response;
    logic               absEncoderFitted = 1'b1;
    logic signed [31:0] encoderPosUser   = 32'sh0000_0000;
    logic               stepRotationMode;
    logic               deviceReady;
    logic        [31:0] linkActive;
    note_t              notes[$];
    note_t              seen;
    int                 errors           = 0;
    int                 n_checks         = 0;
    logic        [31:0] pos;
    logic        [31:0] val;
    logic        [31:0] expAct;
    logic        [31:0] vals[8];

    always #4 clk = ~clk;

    fbcfg_regs #(.SWITCHABLE(MASK), .MS_CYCLES(4)) u_fbcfg_regs (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .response(response), .absEncoderFitted(absEncoderFitted),
        .encoderPosUser(encoderPosUser),
        .stepRotationMode(stepRotationMode), .deviceReady(deviceReady),
        .linkActive(linkActive));

    // ------------------------------------------------------------
    // compare, close and bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // one avalon access; the note is queued before the request rises
    task automatic bus(input logic wr, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       input logic [31:0] expD, input logic [1:0] expR);
        int    n;
        note_t nt;
        nt.d = expD;
        nt.r = expR;
        nt.useD = !wr;
        notes.push_back(nt);
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        n = 0;
        // read right after the edge, waitrequest is the value it sampled
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            check("waitrequest", 32'h0, 32'h1);
            close_out();
        end else begin
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF, 32'h0, 2'h0);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hF, e, 2'h0);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // monitor: every answered access retires the oldest note
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst_b && (read || write) && waitrequest === 1'b0) begin
            if (notes.size() == 0) begin
                check("note queue", 32'h1, 32'h0);
            end else begin
                seen = notes.pop_front();
                check("response", {30'h0, seen.r}, {30'h0, response});
                if (seen.useD) check("readdata", seen.d, readdata);
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        pos = $urandom(3);
        pos = $urandom | 32'h8000_0000; // negative position
        encoderPosUser <= pos;
        repeat (2) @(posedge clk);
        check("deviceReady", 32'h0, {31'h0, deviceReady});
        check("linkActive", 32'h001B_0011, linkActive);
        rst_b <= 1'b1;
        // move the position only after the capture edge has passed
        repeat (2) @(posedge clk);
        encoderPosUser <= ~pos;
        repeat (2) @(posedge clk);
        check("deviceReady", 32'h1, {31'h0, deviceReady});
        rd(IDX_BOOT_DELAY, 32'h0);
        rd(IDX_STEP_MODE, 32'h0);
        rd(IDX_PRESENCE, 32'h001B_0011);
        rd(IDX_ENABLE_CTRL, 32'h001B_0011);
        rd(IDX_ENC_BOOT_POS, pos);
        rd(IDX_READY_STAT, 32'h1);
        // read-only places keep their content under writes
        wr(IDX_ENC_BOOT_POS, ~pos);
        rd(IDX_ENC_BOOT_POS, pos);
        wr(IDX_PRESENCE, $urandom);
        rd(IDX_PRESENCE, 32'h001B_0011);
        // both step input modes, rotation first
        for (int m = 1; m >= 0; m--) begin
            wr(IDX_STEP_MODE, 32'(m));
            rd(IDX_STEP_MODE, 32'(m));
            check("stepRotationMode", 32'(m), {31'h0, stepRotationMode});
        end
        // byte lanes merge; a late delay leaves ready standing
        wr(IDX_BOOT_DELAY, 32'h1122_3344);
        bus(1'b1, IDX_BOOT_DELAY, 32'hAABB_CCDD, 4'h5, 32'h0, 2'h0);
        rd(IDX_BOOT_DELAY, 32'h11BB_33DD);
        check("deviceReady", 32'h1, {31'h0, deviceReady});
        rd(IDX_SWITCH_MASK, MASK);
        // control words: extremes, single links and random patterns
        vals = '{32'h0, 32'hFFFF_FFFF, 32'h0002_0000, 32'h0000_0010,
                 32'h0001_0000, $urandom, $urandom, 32'h001B_0011};
        foreach (vals[i]) begin
            val = vals[i];
            expAct = (32'h001B_0011 & ~MASK) | (val & 32'h001B_0011 & MASK);
            wr(IDX_ENABLE_CTRL, val);
            rd(IDX_ENABLE_CTRL, val);
            check("linkActive", expAct, linkActive);
            rd(IDX_ACTIVE_STAT, expAct);
        end
        // unmapped index: error response, zero data, write dropped
        bus(1'b0, 16'h2000, 32'h0, 4'hF, 32'h0, 2'h2);
        bus(1'b1, 16'h2000, $urandom, 4'hF, 32'h0, 2'h2);
        bus(1'b0, 16'h2000, 32'h0, 4'hF, 32'h0, 2'h2);
        // second boot without an absolute encoder
        wr(IDX_ENABLE_CTRL, 32'h0);
        absEncoderFitted <= 1'b0;
        do_reset();
        rd(IDX_ENC_BOOT_POS, 32'h0);
        rd(IDX_ENABLE_CTRL, 32'h001B_0011);
        check("linkActive", 32'h001B_0011, linkActive);
        rd(IDX_BOOT_DELAY, 32'h0);
        check("stepRotationMode", 32'h0, {31'h0, stepRotationMode});
        close_out();
    end
endmodule
